// ---- hw/stp_second_tick.sv ----
// Contract
// RL1 - one positive pulse per second, four microseconds wide
// RL2 - rising edge lands on the UTC second boundary within 40 ns
// RL3 - consumer times only from the rising edge, ignoring the fall
// RL4 - output stays low until satellite time and position fixes exist
// RL5 - pulses begin as soon as self-survey completes
// RL6 - binary packets both ways; NMEA mode transmits only
// RL7 - health report sent every few seconds, even without satellites
// RL8 - port acts as DCE; terminal hosts wire straight through
// RL9 - commands within about 2.1 s of power-up are discarded
// RL10 - period counter realigned to each new time solution
//
// stp_second_tick: second tick pulse generator and serial port duties
// assumes navigation core status and solutions synchronous to clk
`timescale 1ns/1ps
module stp_second_tick
   import stp_pkg::*;
#(
   parameter int SECOND_CYCLES = SECOND_CYCLES_DEF,
   parameter int QUIET_CYCLES  = QUIET_CYCLES_DEF,
   parameter int HEALTH_CYCLES = HEALTH_CYCLES_DEF
)(
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic          clk_en,
   input  wire stp_nav_t      nav,
   input  wire stp_solution_t solution,
   input  wire stp_proto_t    proto,
   input  wire logic          cmd_valid,
   output logic               cmd_accept,
   output logic               cmd_drop,
   output logic               tx_enable,
   output logic               health_req,
   output logic               second_tick_pulse
);

   // ---------------------------------------------------------------
   // gating state
   // ---------------------------------------------------------------
   stp_state_t       state;
   stp_state_t       next_state;
   logic [CNT_W-1:0] sec_cnt;
   logic [PW_W-1:0]  pw_cnt;
   logic             boundary;

   assign boundary = (sec_cnt == CNT_ZERO);

   always_comb begin
      next_state = state;
      case (state)
         STP_ST_WAIT_FIX: begin
            if (nav.time_ok && nav.fix_ok)                 // [RL4]
               next_state = STP_ST_SURVEY;
         end
         STP_ST_SURVEY: begin
            if (!(nav.time_ok && nav.fix_ok))
               next_state = STP_ST_WAIT_FIX;
            else if (nav.survey_done)                      // [RL5]
               next_state = STP_ST_RUN;
         end
         STP_ST_RUN: begin
            if (!(nav.time_ok && nav.fix_ok))
               next_state = STP_ST_WAIT_FIX;
         end
         default: next_state = STP_ST_WAIT_FIX;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         state <= STP_ST_WAIT_FIX;
      else if (clk_en)
         state <= next_state;
   end

   // ---------------------------------------------------------------
   // one second counter
   // ---------------------------------------------------------------
   // counts down; zero marks the boundary, a solution reloads phase
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         sec_cnt <= CNT_ZERO;
      else if (clk_en) begin
         if (solution.valid)                               // [RL10]
            sec_cnt <= solution.phase;
         else if (boundary)
            sec_cnt <= CNT_W'(SECOND_CYCLES - 1);
         else
            sec_cnt <= sec_cnt - 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // pulse shaper
   // ---------------------------------------------------------------
   // rising edge registered at the boundary cycle itself
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         second_tick_pulse <= 1'b0;
         pw_cnt            <= '0;
      end else if (clk_en) begin
         if (state != STP_ST_RUN) begin                    // [RL4]
            second_tick_pulse <= 1'b0;
            pw_cnt            <= '0;
         end else if (boundary && !solution.valid) begin   // [RL2]
            second_tick_pulse <= 1'b1;                     // [RL1]
            pw_cnt            <= '0;
         end else if (second_tick_pulse) begin
            if (pw_cnt == PW_LAST)
               second_tick_pulse <= 1'b0;                  // [RL1]
            else
               pw_cnt <= pw_cnt + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // serial port duties
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] quiet_cnt;
   logic             quiet_done;
   logic [CNT_W-1:0] health_cnt;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         quiet_cnt  <= CNT_ZERO;
         quiet_done <= 1'b0;
      end else if (clk_en && !quiet_done) begin
         if (quiet_cnt == CNT_W'(QUIET_CYCLES - 1))        // [RL9]
            quiet_done <= 1'b1;
         else
            quiet_cnt <= quiet_cnt + 1'b1;
      end
   end

   // dce port: host receive pin carries our transmit data
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cmd_accept <= 1'b0;
         cmd_drop   <= 1'b0;
         tx_enable  <= 1'b0;
      end else if (clk_en) begin
         tx_enable  <= 1'b1;                               // [RL8]
         cmd_accept <= cmd_valid && quiet_done
                       && (proto == STP_PROTO_BINARY);     // [RL6]
         cmd_drop   <= cmd_valid && (!quiet_done
                       || (proto == STP_PROTO_NMEA));      // [RL9] [RL6]
      end
   end

   // health report runs regardless of tracking state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         health_cnt <= CNT_ZERO;
         health_req <= 1'b0;
      end else if (clk_en) begin
         if (health_cnt == CNT_W'(HEALTH_CYCLES - 1)) begin // [RL7]
            health_cnt <= CNT_ZERO;
            health_req <= 1'b1;
         end else begin
            health_cnt <= health_cnt + 1'b1;
            health_req <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_pulse_width_hold: assert property (                    // [RL1]
      @(posedge clk) disable iff (!resetn)
      ($rose(second_tick_pulse) && clk_en && state == STP_ST_RUN
       && !solution.valid) |=> second_tick_pulse)
      else $error("tick pulse dropped after one cycle");

   a_pulse_on_boundary: assert property (                   // [RL2]
      @(posedge clk) disable iff (!resetn)
      $rose(second_tick_pulse) |-> $past(boundary))
      else $error("tick rose away from the second boundary");

   a_idle_until_fix: assert property (                      // [RL4]
      @(posedge clk) disable iff (!resetn)
      ($past(state) != STP_ST_RUN && $past(clk_en))
      |-> !second_tick_pulse)
      else $error("tick present before fix and survey");

   a_survey_release: assert property (                      // [RL5]
      @(posedge clk) disable iff (!resetn)
      (clk_en && state == STP_ST_SURVEY && nav.time_ok && nav.fix_ok
       && nav.survey_done) |=> state == STP_ST_RUN)
      else $error("survey end did not release the tick");

   a_nmea_no_accept: assert property (                      // [RL6]
      @(posedge clk) disable iff (!resetn)
      (clk_en && proto == STP_PROTO_NMEA) |=> !cmd_accept)
      else $error("command accepted in nmea mode");

   a_early_cmd_drop: assert property (                      // [RL9]
      @(posedge clk) disable iff (!resetn)
      (clk_en && cmd_valid && !quiet_done) |=> cmd_drop && !cmd_accept)
      else $error("early command not discarded");

   a_realign_load: assert property (                        // [RL10]
      @(posedge clk) disable iff (!resetn)
      (clk_en && solution.valid) |=> sec_cnt == $past(solution.phase))
      else $error("counter not realigned to solution");

   a_health_single: assert property (                       // [RL7]
      @(posedge clk) disable iff (!resetn)
      (health_req && clk_en) |=> !health_req)
      else $error("health request longer than one cycle");

   // first edge after release still shows the reset value
   a_tx_driven: assert property (                           // [RL8]
      @(posedge clk) disable iff (!resetn)
      ($past(clk_en) && $past(resetn)) |-> tx_enable)
      else $error("transmit line not driven");

   a_width_end: assert property (                           // [RL1]
      @(posedge clk) disable iff (!resetn)
      (clk_en && state == STP_ST_RUN && second_tick_pulse
       && pw_cnt == PW_LAST && !boundary) |=> !second_tick_pulse)
      else $error("tick pulse not ended after its width");

   a_freeze_count: assert property (                        // [RL10]
      @(posedge clk) disable iff (!resetn)
      !clk_en |=> $stable(sec_cnt))
      else $error("second counter moved while frozen");

   a_cmd_exclusive: assert property (                       // [RL6]
      @(posedge clk) disable iff (!resetn)
      !(cmd_accept && cmd_drop))
      else $error("command both accepted and dropped");

endmodule : stp_second_tick

// ---- common/stp_pkg.sv ----
// stp_pkg: constants and carrier types for the second tick pulse block
// assumes a 100 MHz reference clock; all counts derive from that rate
package stp_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS      = 10;
   localparam int PULSE_WIDTH_NS     = 4000;
   localparam int PULSE_CYCLES       = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int SECOND_NS          = 1000000000;
   localparam int SECOND_CYCLES_DEF  = SECOND_NS / CLK_PERIOD_NS;
   localparam int QUIET_MS           = 2100;
   localparam int QUIET_CYCLES_DEF   = QUIET_MS * 100000;
   localparam int HEALTH_MS          = 3000;
   localparam int HEALTH_CYCLES_DEF  = HEALTH_MS * 100000;
   localparam int ACCURACY_NS        = 40;
   localparam int SURVEY_MIN         = 30;

   localparam int CNT_W              = 32;
   localparam int PW_W               = 9;
   localparam logic [PW_W-1:0] PW_LAST = PW_W'(PULSE_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;

   // ---------------------------------------------------------------
   // serial port protocol selection
   // ---------------------------------------------------------------
   typedef enum logic [0:0] {
      STP_PROTO_BINARY = 1'b0,
      STP_PROTO_NMEA   = 1'b1
   } stp_proto_t;

   // ---------------------------------------------------------------
   // output pulse gating states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      STP_ST_WAIT_FIX    = 2'b00,
      STP_ST_SURVEY      = 2'b01,
      STP_ST_RUN         = 2'b10
   } stp_state_t;

   // time solution from the navigation core
   typedef struct packed {
      logic             valid;
      logic [CNT_W-1:0] phase;
   } stp_solution_t;

   // status from the navigation core
   typedef struct packed {
      logic time_ok;
      logic fix_ok;
      logic survey_done;
   } stp_nav_t;

endpackage : stp_pkg

// ---- tb/stp_host_model.sv ----
// stp_host_model: user timing logic watching the second tick pulse
// assumes the pulse is synchronous to clk
`timescale 1ns/1ps
module stp_host_model (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic tick,
   output int        period,
   output int        width,
   output int        rises
);
   logic last;
   int   gap;
   int   hi;
   // ---------------------------------------------------------------
   // edge timing
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         last   <= 1'b0;
         gap    <= 0;
         hi     <= 0;
         period <= 0;
         width  <= 0;
         rises  <= 0;
      end else begin
         last <= tick;
         gap  <= gap + 1;
         // period taken from the rise only; the fall only closes the width count
         if (tick && !last) begin
            period <= gap;
            gap    <= 1;
            rises  <= rises + 1;
         end
         if (tick) hi <= hi + 1;
         else if (last) begin
            width <= hi;
            hi    <= 0;
         end
      end
   end
endmodule : stp_host_model

// ---- tb/tb_stp_second_tick.sv ----
// tb_stp_second_tick: self-checking bench for the second tick block
// assumes short counts: second 1000, quiet 50, health 200 cycles
`timescale 1ns/1ps
module tb_stp_second_tick;
   import stp_pkg::*;
   logic          clk = 1'b0;
   logic          resetn = 1'b0;
   logic          en = 1'b1;
   stp_nav_t      nav = '0;
   stp_solution_t solution = '0;
   stp_proto_t    proto = STP_PROTO_BINARY;
   logic          cmd_valid = 1'b0;
   logic          cmd_accept, cmd_drop, tx_enable, health_req, tick;
   int            period, width, rises, n;
   int            num_errors = 0;
   int            tests_run = 0;
   always #5 clk = ~clk;
   stp_second_tick #(.SECOND_CYCLES(1000), .QUIET_CYCLES(50),
      .HEALTH_CYCLES(200)) uut (.clk(clk), .resetn(resetn),
      .clk_en(en), .nav(nav), .solution(solution), .proto(proto),
      .cmd_valid(cmd_valid), .cmd_accept(cmd_accept),
      .cmd_drop(cmd_drop), .tx_enable(tx_enable),
      .health_req(health_req), .second_tick_pulse(tick));
   stp_host_model host (.clk(clk), .resetn(resetn), .tick(tick),
      .period(period), .width(width), .rises(rises));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task final_report;
      $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk
   // cycles until a rise of tick (sel 0) or health_req (sel 1)
   task wait_rise(input bit sel, input int lim, output int c);
      logic p;
      p = sel ? health_req : tick;
      for (c = 1; c <= lim; c++) begin
         @(posedge clk);
         #1;
         if ((sel ? health_req : tick) === 1'b1 && p !== 1'b1) return;
         p = sel ? health_req : tick;
      end
      num_errors++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, 0, 1);
      final_report();
   endtask : wait_rise
   task no_tick(input int k);
      repeat (k) begin
         @(posedge clk);
         #1;
         if (tick !== 1'b0) chk(tick, 0);
      end
      chk(tick, 0);
   endtask : no_tick
   task cmd(input logic acc);
      @(posedge clk) cmd_valid <= 1'b1;
      @(posedge clk) cmd_valid <= 1'b0;
      #1 chk(cmd_accept, acc);
      chk(cmd_drop, !acc);
   endtask : cmd
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_commands;
      cmd(1'b0);
      chk(tx_enable, 1);
      repeat (60) @(posedge clk);
      cmd_valid <= 1'b1;
      @(posedge clk);
      @(posedge clk) cmd_valid <= 1'b0;
      #1 chk(cmd_accept, 1);
      @(posedge clk) proto <= STP_PROTO_NMEA;
      cmd(1'b0);
      @(posedge clk) proto <= STP_PROTO_BINARY;
      cmd(1'b1);
      $display("t_commands done");
   endtask : t_commands
   task t_health;
      wait_rise(1, 205, n);
      wait_rise(1, 205, n);
      chk(n, 200);
      $display("t_health done");
   endtask : t_health
   task t_gating;
      no_tick(1100);
      @(posedge clk) nav <= '{1'b1, 1'b1, 1'b0};
      no_tick(1100);
      @(posedge clk) nav <= '{1'b1, 1'b1, 1'b1};
      wait_rise(0, 1005, n);
      $display("t_gating done");
   endtask : t_gating
   task t_period;
      wait_rise(0, 1002, n);
      chk(n, 1000);
      repeat (405) @(posedge clk);
      chk(period, 1000);
      chk(width, 400);
      $display("t_period done");
   endtask : t_period
   task t_align;
      @(posedge clk) solution <= '{1'b1, 32'h0000_012C};
      @(posedge clk) solution.valid <= 1'b0;
      wait_rise(0, 700, n);
      chk(n, 301);
      wait_rise(0, 1002, n);
      chk(n, 1000);
      $display("t_align done");
   endtask : t_align
   task t_freeze;
      @(posedge clk) en <= 1'b0;
      repeat (50) @(posedge clk);
      #1 chk(tick, 1);
      @(posedge clk) en <= 1'b1;
      wait_rise(0, 1002, n);
      // one enabled edge ran before the freeze
      chk(n, 999);
      $display("t_freeze done");
   endtask : t_freeze
   task t_loss;
      @(posedge clk) nav.fix_ok <= 1'b0;
      repeat (2) @(posedge clk);
      no_tick(1100);
      $display("t_loss done");
   endtask : t_loss
   initial begin
      @(posedge clk);
      #1 chk({cmd_accept, cmd_drop, health_req, tick}, 0);
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_commands();
      t_health();
      t_gating();
      t_period();
      t_align();
      t_freeze();
      t_loss();
      final_report();
   end
endmodule : tb_stp_second_tick
